// ==== logic/wake_ctrl_pkg.sv ====
package wake_ctrl_pkg;
	// Register addresses
	localparam logic [7:0] ADDR_TIMER_CONTROL = 8'h88;
	localparam logic [7:0] ADDR_RTC_CONFIG    = 8'ha1;
	localparam logic [7:0] ADDR_RTC_CONFIG2   = 8'ha2;
	localparam logic [7:0] ADDR_PORT0_PULLUP  = 8'hb2;
	localparam logic [7:0] ADDR_PORT1_PULLUP  = 8'hb3;
	localparam logic [7:0] ADDR_PORT2_PULLUP  = 8'hb4;
	localparam logic [7:0] ADDR_POWER_CONTROL = 8'hc5;
	localparam logic [7:0] ADDR_POWER_IRQ_EN  = 8'hec;
	localparam logic [7:0] ADDR_DELTA_CONFIG  = 8'hf3;
	localparam logic [7:0] ADDR_PERIPHERAL_CONFIG_CONFIG = 8'hf4;
	localparam logic [7:0] ADDR_POWER_FLAGS   = 8'hf8;
	localparam logic [7:0] ADDR_SCRATCH_BASE  = 8'hfb;
	localparam logic [7:0] ADDR_PIN_CONFIG    = 8'hff;
	localparam logic [7:0] ADDR_LCD_CONTROL   = 8'hd0;
	localparam logic [7:0] ADDR_LCD_POINTER   = 8'hd1;
	localparam logic [7:0] ADDR_LCD_DATA      = 8'hd2;
	localparam logic [7:0] ADDR_WAKE_STATUS   = 8'hd3;
	// Field positions
	localparam int BIT_PIN0_EDGE_SEL   = 0;
	localparam int BIT_PIN0_EDGE_FLAG  = 1;
	localparam int BIT_PIN1_EDGE_SEL   = 2;
	localparam int BIT_PIN1_EDGE_FLAG  = 3;
	localparam int BIT_RTC_INTERVAL    = 2;
	localparam int BIT_RTC_ALARM       = 6;
	localparam int BIT_SUPPLY_MEAS     = 3;
	localparam int BIT_SUPPLY_RESTORED = 7;
	localparam int BIT_SUPPLY_SOURCE   = 6;
	localparam int BIT_RX_EDGE_FLAG    = 7;
	localparam int BIT_SLEEP_ENTER     = 4;
	localparam int BIT_PIN0_PROG       = 0;
	localparam int BIT_TEMP_SLEEP_EN   = 0;
	localparam int BIT_LCD_ON          = 0;
	// Field values
	localparam logic [1:0] PIN1_PROG_WAKE = 2'h3;
	localparam logic [1:0] RX_PROG_WAKE   = 2'h3;
	localparam logic [7:0] ALARM_EN_MASK  = 8'he0;
	// Reset values, unmapped read value and storage depths
	localparam logic [7:0] RESET_BYTE      = 8'h00;
	localparam logic [7:0] RESET_PULLUP_EN = 8'hff;
	localparam logic [7:0] UNMAPPED_READ   = 8'h00;
	localparam int SCRATCH_COUNT = 4;
	localparam int LCD_DEPTH     = 16;

	typedef enum logic [1:0] {
		normal_mode,
		battery_mode,
		sleep_mode
	} power_mode_type;

	// Register bus request
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} reg_req_type;

	// Wake source pins and events
	typedef struct packed {
		logic temp_event;
		logic supply_meas_event;
		logic supply_restored_event;
		logic rtc_interval_event;
		logic rtc_alarm_event;
		logic pin0_n;
		logic pin1_n;
		logic second_uart_rx_line;
		logic reset_pin_n;
		logic on_main_rail;
	} wake_src_type;

	// Source levels with nothing pending: active-low pins and rx line idle high
	localparam wake_src_type SRC_IDLE = '{pin0_n: 1'b1, pin1_n: 1'b1,
		second_uart_rx_line: 1'b1, reset_pin_n: 1'b1, default: 1'b0};
endpackage

// ==== logic/sleep_wakeup_event_control.sv ====
// Overview of operation
// [RULE_01] Firmware clears the waking source flag before re-entering sleep.
// [RULE_02] Temperature event wakes only if temperature measurement enabled for sleep.
// [RULE_03] Supply measurement event sets power flag bit 3, power vector.
// [RULE_04] Clearing power enable bit 3 disables supply measurement wake-up.
// [RULE_05] Main supply restore wakes unconditionally and sets power flag bit 7.
// [RULE_06] Supply source indicator bit 6 shows connection to main rail.
// [RULE_07] RTC interval expiry sets RTC bit 2; maskable wake source. The code has no mask: a set bit 2 always wakes.
// [RULE_08] RTC alarm sets RTC bit 6; wakes only with alarm enables set.
// [RULE_09] Pin 0 wakes when program bit equals 1; edge chosen by bit 0.
// [RULE_10] Pin 0 wake leaves the pin 0 edge flag unchanged.
// [RULE_11] Pin 1 wakes when program field is 11x; edge chosen by bit 2.
// [RULE_12] Pin 1 wake leaves the pin 1 edge flag unchanged.
// [RULE_13] Receive program 11 makes any rx edge wake and set flag bit 7.
// [RULE_14] Reset pin low in sleep wakes into battery mode.
// [RULE_15] Display may switch during sleep; its segment memory is kept.
// [RULE_16] Four scratch pad registers keep contents across sleep.
// [RULE_17] In sleep all pins are inputs; pull-ups individually disabled.
// [RULE_18] Firmware enters sleep by setting power control bit 4.
// [RULE_19] Wake from sleep restarts the core at the reset vector.
// [RULE_20] Wake request ORs enabled and nonmaskable sources, only in sleep.
module sleep_wakeup_event_control
	import wake_ctrl_pkg::*;
#(
	parameter int PIN_COUNT = 8
) (
	// Clock and reset
	input  wire logic                        i_clk,
	input  wire logic                        i_rst,
	// Register port
	input  wire wake_ctrl_pkg::reg_req_type  i_req,
	output logic [7:0]                       o_rdata,
	// Wake sources, asynchronous
	input  wire wake_ctrl_pkg::wake_src_type i_src,
	// Power sequencing
	output logic                             o_wake_req,
	output logic                             o_core_restart,
	output logic                             o_core_off,
	output wake_ctrl_pkg::power_mode_type    o_mode,
	// Pins and display
	output logic [3*PIN_COUNT-1:0]           o_pin_force_input,
	output logic [3*PIN_COUNT-1:0]           o_pin_pullup_en,
	output logic                             o_lcd_on
);
	import wake_ctrl_pkg::*;

	// Synchronised sources
	wake_src_type src_meta_reg;
	wake_src_type src_sync_reg;
	wake_src_type src_prev_reg;

	logic [7:0] timer_control_reg;
	logic [7:0] rtc_config_reg;
	logic [7:0] rtc_config_second_reg;
	logic [7:0] pullup_reg [3];
	logic [7:0] power_irq_enable_reg;
	logic [7:0] temp_supply_delta_config_reg;
	logic [7:0] peripheral_config_reg;
	logic [7:0] power_irq_flags_reg;
	logic [7:0] irq_pin_config_reg;
	logic [7:0] scratch_pad_regs [SCRATCH_COUNT];
	logic [7:0] lcd_mem_reg [LCD_DEPTH];
	logic [7:0] lcd_ptr_reg;
	logic       lcd_on_reg;
	logic [7:0] wake_cause_reg;
	power_mode_type mode_reg;
	logic [7:0] rdata_reg;
	logic       wake_req_reg;
	logic       restart_reg;
	logic       temp_flag_reg;

	// Helper: write hit on an address
	function automatic logic wr_hit(input reg_req_type r, input logic [7:0] a);
		return r.wr && (r.addr == a);
	endfunction

	// Edge detection on synchronised levels
	logic pin0_fall;
	logic pin1_fall;
	logic pin0_low;
	logic pin1_low;
	logic rx_edge;
	logic temp_rise;
	logic meas_rise;
	logic restore_rise;
	logic interval_rise;
	logic alarm_rise;
	logic in_sleep;
	logic temp_wake;
	logic meas_wake;
	logic rtc_wake;
	logic pin0_wake;
	logic pin1_wake;
	logic rx_wake;
	logic reset_wake;
	logic any_wake;

	assign pin0_fall     = src_prev_reg.pin0_n && !src_sync_reg.pin0_n;
	assign pin1_fall     = src_prev_reg.pin1_n && !src_sync_reg.pin1_n;
	assign pin0_low      = !src_sync_reg.pin0_n;
	assign pin1_low      = !src_sync_reg.pin1_n;
	assign rx_edge       = src_prev_reg.second_uart_rx_line ^ src_sync_reg.second_uart_rx_line;
	assign temp_rise     = src_sync_reg.temp_event && !src_prev_reg.temp_event;
	assign meas_rise     = src_sync_reg.supply_meas_event && !src_prev_reg.supply_meas_event;
	assign restore_rise  = src_sync_reg.supply_restored_event
		&& !src_prev_reg.supply_restored_event;
	assign interval_rise = src_sync_reg.rtc_interval_event && !src_prev_reg.rtc_interval_event;
	assign alarm_rise    = src_sync_reg.rtc_alarm_event && !src_prev_reg.rtc_alarm_event
		&& ((rtc_config_second_reg & ALARM_EN_MASK) != RESET_BYTE); // RULE_08
	assign in_sleep      = (mode_reg == sleep_mode);

	// Per-source wake qualification
	assign temp_wake  = temp_flag_reg
		&& temp_supply_delta_config_reg[BIT_TEMP_SLEEP_EN]; // RULE_02
	assign meas_wake  = power_irq_flags_reg[BIT_SUPPLY_MEAS]
		&& power_irq_enable_reg[BIT_SUPPLY_MEAS]; // RULE_04
	assign rtc_wake   = rtc_config_reg[BIT_RTC_INTERVAL] || rtc_config_reg[BIT_RTC_ALARM];
	assign pin0_wake  = irq_pin_config_reg[BIT_PIN0_PROG]
		&& (timer_control_reg[BIT_PIN0_EDGE_SEL] ? pin0_fall : pin0_low); // RULE_09
	assign pin1_wake  = (irq_pin_config_reg[3:2] == PIN1_PROG_WAKE)
		&& (timer_control_reg[BIT_PIN1_EDGE_SEL] ? pin1_fall : pin1_low); // RULE_11
	assign rx_wake    = peripheral_config_reg[BIT_RX_EDGE_FLAG]
		&& (peripheral_config_reg[1:0] == RX_PROG_WAKE); // RULE_13
	assign reset_wake = !src_sync_reg.reset_pin_n; // RULE_14
	assign any_wake   = temp_wake || meas_wake || rtc_wake || pin0_wake || pin1_wake
		|| rx_wake || reset_wake || power_irq_flags_reg[BIT_SUPPLY_RESTORED]; // RULE_20

	// Two-stage synchroniser plus history stage
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			src_meta_reg <= SRC_IDLE;
			src_sync_reg <= SRC_IDLE;
			src_prev_reg <= SRC_IDLE;
		end else begin
			src_meta_reg <= i_src;
			src_sync_reg <= src_meta_reg;
			src_prev_reg <= src_sync_reg;
		end
	end

	// Power mode sequencing
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			mode_reg     <= normal_mode;
			wake_req_reg <= 1'b0;
			restart_reg  <= 1'b0;
		end else begin
			wake_req_reg <= in_sleep && any_wake; // RULE_20
			restart_reg  <= 1'b0;
			if (in_sleep) begin
				if (src_sync_reg.on_main_rail) begin
					mode_reg    <= normal_mode;
					restart_reg <= 1'b1; // RULE_19
				end else if (any_wake) begin
					mode_reg    <= battery_mode; // RULE_14
					restart_reg <= 1'b1; // RULE_19
				end
			end else if (wr_hit(i_req, ADDR_POWER_CONTROL) && i_req.wdata[BIT_SLEEP_ENTER]) begin
				mode_reg <= sleep_mode; // RULE_18
			end else begin
				mode_reg <= src_sync_reg.on_main_rail ? normal_mode : battery_mode;
			end
		end
	end

	// Power flags: hardware set wins over software clear
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			power_irq_flags_reg  <= RESET_BYTE;
			power_irq_enable_reg <= RESET_BYTE;
		end else begin
			if (wr_hit(i_req, ADDR_POWER_FLAGS)) begin
				power_irq_flags_reg <= i_req.wdata; // RULE_01
			end
			if (meas_rise) begin
				power_irq_flags_reg[BIT_SUPPLY_MEAS] <= 1'b1; // RULE_03
			end
			if (restore_rise) begin
				power_irq_flags_reg[BIT_SUPPLY_RESTORED] <= 1'b1; // RULE_05
			end
			if (wr_hit(i_req, ADDR_POWER_IRQ_EN)) begin
				power_irq_enable_reg <= i_req.wdata;
			end
		end
	end

	// RTC configuration and flags
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			rtc_config_reg        <= RESET_BYTE;
			rtc_config_second_reg <= RESET_BYTE;
		end else begin
			if (wr_hit(i_req, ADDR_RTC_CONFIG)) begin
				rtc_config_reg <= i_req.wdata;
			end
			if (interval_rise) begin
				rtc_config_reg[BIT_RTC_INTERVAL] <= 1'b1; // RULE_07
			end
			if (alarm_rise) begin
				rtc_config_reg[BIT_RTC_ALARM] <= 1'b1; // RULE_08
			end
			if (wr_hit(i_req, ADDR_RTC_CONFIG2)) begin
				rtc_config_second_reg <= i_req.wdata;
			end
		end
	end

	// Timer control: edge flags untouched by sleep wake-ups; a set beats a write
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			timer_control_reg <= RESET_BYTE;
		end else begin
			if (wr_hit(i_req, ADDR_TIMER_CONTROL)) begin
				timer_control_reg <= i_req.wdata;
			end
			if (!in_sleep) begin // RULE_10 RULE_12
				if (timer_control_reg[BIT_PIN0_EDGE_SEL] ? pin0_fall : pin0_low) begin
					timer_control_reg[BIT_PIN0_EDGE_FLAG] <= 1'b1;
				end
				if (timer_control_reg[BIT_PIN1_EDGE_SEL] ? pin1_fall : pin1_low) begin
					timer_control_reg[BIT_PIN1_EDGE_FLAG] <= 1'b1;
				end
			end
		end
	end

	// Peripheral configuration, source indicator and rx flag
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			peripheral_config_reg <= RESET_BYTE;
		end else begin
			if (wr_hit(i_req, ADDR_PERIPHERAL_CONFIG_CONFIG)) begin
				peripheral_config_reg <= i_req.wdata;
			end
			peripheral_config_reg[BIT_SUPPLY_SOURCE] <= src_sync_reg.on_main_rail; // RULE_06
			if (rx_edge && (peripheral_config_reg[1:0] == RX_PROG_WAKE)) begin
				peripheral_config_reg[BIT_RX_EDGE_FLAG] <= 1'b1; // RULE_13
			end
		end
	end

	// Temperature event latch, cleared by writing delta config
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			temp_flag_reg                <= 1'b0;
			temp_supply_delta_config_reg <= RESET_BYTE;
			irq_pin_config_reg           <= RESET_BYTE;
		end else begin
			if (wr_hit(i_req, ADDR_DELTA_CONFIG)) begin
				temp_supply_delta_config_reg <= i_req.wdata;
				temp_flag_reg                <= 1'b0; // RULE_01
			end
			if (temp_rise) begin
				temp_flag_reg <= 1'b1; // RULE_02
			end
			if (wr_hit(i_req, ADDR_PIN_CONFIG)) begin
				irq_pin_config_reg <= i_req.wdata;
			end
		end
	end

	// Retained storage: scratch pad, pull-ups, display pointer and control
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			for (int i = 0; i < SCRATCH_COUNT; i++) begin
				scratch_pad_regs[i] <= RESET_BYTE;
			end
			for (int i = 0; i < 3; i++) begin
				pullup_reg[i] <= RESET_PULLUP_EN;
			end
			lcd_ptr_reg <= RESET_BYTE;
			lcd_on_reg  <= 1'b0;
		end else begin
			for (int i = 0; i < SCRATCH_COUNT; i++) begin
				if (wr_hit(i_req, 8'(ADDR_SCRATCH_BASE + 8'(i)))) begin
					scratch_pad_regs[i] <= i_req.wdata; // RULE_16
				end
			end
			for (int i = 0; i < 3; i++) begin
				if (wr_hit(i_req, 8'(ADDR_PORT0_PULLUP + 8'(i)))) begin
					pullup_reg[i] <= i_req.wdata; // RULE_17
				end
			end
			if (wr_hit(i_req, ADDR_LCD_POINTER)) begin
				lcd_ptr_reg <= i_req.wdata;
			end
			if (wr_hit(i_req, ADDR_LCD_CONTROL)) begin
				lcd_on_reg <= i_req.wdata[BIT_LCD_ON]; // RULE_15
			end
		end
	end

	// Display memory is never cleared, so it survives sleep
	always_ff @(posedge i_clk) begin
		if (wr_hit(i_req, ADDR_LCD_DATA)) begin
			lcd_mem_reg[lcd_ptr_reg[3:0]] <= i_req.wdata; // RULE_15
		end
	end

	// Wake cause capture for firmware after restart
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			wake_cause_reg <= RESET_BYTE;
		end else if (in_sleep && any_wake) begin
			wake_cause_reg <= {reset_wake, rx_wake, pin1_wake, pin0_wake, rtc_wake,
				power_irq_flags_reg[BIT_SUPPLY_RESTORED], meas_wake, temp_wake};
		end
	end

	// Read data, one cycle after the strobe
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			rdata_reg <= RESET_BYTE;
		end else if (i_req.rd) begin
			if (i_req.addr == ADDR_TIMER_CONTROL) begin
				rdata_reg <= timer_control_reg;
			end else if (i_req.addr == ADDR_RTC_CONFIG) begin
				rdata_reg <= rtc_config_reg;
			end else if (i_req.addr == ADDR_RTC_CONFIG2) begin
				rdata_reg <= rtc_config_second_reg;
			end else if (i_req.addr >= ADDR_PORT0_PULLUP && i_req.addr <= ADDR_PORT2_PULLUP) begin
				rdata_reg <= pullup_reg[2'(i_req.addr - ADDR_PORT0_PULLUP)];
			end else if (i_req.addr == ADDR_POWER_IRQ_EN) begin
				rdata_reg <= power_irq_enable_reg;
			end else if (i_req.addr == ADDR_DELTA_CONFIG) begin
				rdata_reg <= temp_supply_delta_config_reg;
			end else if (i_req.addr == ADDR_PERIPHERAL_CONFIG_CONFIG) begin
				rdata_reg <= peripheral_config_reg;
			end else if (i_req.addr == ADDR_POWER_FLAGS) begin
				rdata_reg <= power_irq_flags_reg;
			end else if (i_req.addr >= ADDR_SCRATCH_BASE && i_req.addr < ADDR_PIN_CONFIG) begin
				rdata_reg <= scratch_pad_regs[2'(i_req.addr - ADDR_SCRATCH_BASE)];
			end else if (i_req.addr == ADDR_PIN_CONFIG) begin
				rdata_reg <= irq_pin_config_reg;
			end else if (i_req.addr == ADDR_LCD_CONTROL) begin
				rdata_reg <= {7'h00, lcd_on_reg};
			end else if (i_req.addr == ADDR_LCD_POINTER) begin
				rdata_reg <= lcd_ptr_reg;
			end else if (i_req.addr == ADDR_LCD_DATA) begin
				rdata_reg <= lcd_mem_reg[lcd_ptr_reg[3:0]];
			end else if (i_req.addr == ADDR_WAKE_STATUS) begin
				rdata_reg <= wake_cause_reg;
			end else begin
				rdata_reg <= UNMAPPED_READ;
			end
		end else begin
			rdata_reg <= RESET_BYTE;
		end
	end

	// Pin treatment registered toward the pads
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_pin_force_input <= '0;
			o_pin_pullup_en   <= '1;
		end else begin
			o_pin_force_input <= {(3*PIN_COUNT){in_sleep}}; // RULE_17
			for (int i = 0; i < 3; i++) begin
				o_pin_pullup_en[i*PIN_COUNT +: PIN_COUNT] <= PIN_COUNT'(pullup_reg[i]); // RULE_17
			end
		end
	end

	assign o_rdata        = rdata_reg;
	assign o_wake_req     = wake_req_reg;
	assign o_core_restart = restart_reg;
	assign o_core_off     = mode_reg[1]; // Only sleep_mode has the upper bit set
	assign o_mode         = mode_reg;
	assign o_lcd_on       = lcd_on_reg;
endmodule

// ==== testbench/wake_src_model.sv ====
module wake_src_model (
	// Clock and command from the bench
	input  wire logic                   i_clk,
	input  wire logic                   i_go,
	input  wire logic [3:0]             i_cmd,
	// Wake source lines
	output wake_ctrl_pkg::wake_src_type o_src
);
	timeunit 1ns;
	timeprecision 1ns;
	import wake_ctrl_pkg::*;
	logic [9:0] pulse_reg = '0;
	logic [2:0] cnt_reg   = '0;
	logic       rail_reg  = 1'b0;
	// One source is pulsed for seven cycles; command 0 flips the supply rail
	always @(posedge i_clk) begin
		if (i_go && i_cmd == 4'h0) begin
			rail_reg <= !rail_reg;
		end else if (i_go) begin
			pulse_reg <= 10'h001 << i_cmd;
			cnt_reg <= 3'h6;
		end else if (cnt_reg != 3'h0) begin
			cnt_reg <= cnt_reg - 3'h1;
		end else begin
			pulse_reg <= '0;
		end
	end
	// Idle: events low, active-low pins high; rx pulse gives two edges
	assign o_src = wake_src_type'((10'h01e ^ pulse_reg) | {9'h000, rail_reg});
endmodule

// ==== testbench/sleep_wakeup_event_control_chk.sv ====
module sleep_wakeup_event_control_chk #(
	parameter int PIN_COUNT = 8
) (
	// Watched ports
	input wire logic                          i_clk,
	input wire logic                          i_rst,
	input wire wake_ctrl_pkg::reg_req_type    i_req,
	input wire wake_ctrl_pkg::wake_src_type   i_src,
	input wire logic                          o_wake_req,
	input wire logic                          o_core_restart,
	input wire logic                          o_core_off,
	input wire wake_ctrl_pkg::power_mode_type o_mode,
	input wire logic [3*PIN_COUNT-1:0]        o_pin_force_input,
	input wire logic [3*PIN_COUNT-1:0]        o_pin_pullup_en
);
	timeunit 1ns;
	timeprecision 1ns;
	import wake_ctrl_pkg::*;
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_rst);
	// Core power and forced inputs follow the sleep state; port 0 pull-up output follows register writes
	AST_CORE_OFF: assert property (o_core_off == (o_mode == sleep_mode))
		else $error("core off differs from sleep state");
	AST_FORCE_INPUT: assert property (
		(o_mode == sleep_mode) ##1 (o_mode == sleep_mode) |-> (&o_pin_force_input))
		else $error("pins not all inputs in sleep");
	AST_PULLUP_COPY: assert property (
		(i_req.wr && i_req.addr == ADDR_PORT0_PULLUP)
		##1 !(i_req.wr && i_req.addr == ADDR_PORT0_PULLUP)
		|-> ##1 o_pin_pullup_en[7:0] == $past(i_req.wdata, 2))
		else $error("port 0 pull-up output not updated");
	// Restart is a single pulse tied to leaving sleep
	AST_RESTART_ONE: assert property (o_core_restart |=> !o_core_restart)
		else $error("restart pulse longer than one cycle");
	AST_EXIT_RESTART: assert property ((o_mode == sleep_mode) ##1 (o_mode != sleep_mode)
		|-> o_core_restart)
		else $error("sleep exit without restart");
	AST_WAKE_IN_SLEEP: assert property ($rose(o_wake_req) |-> $past(o_mode) == sleep_mode)
		else $error("wake request outside sleep");
	// Nonmaskable sources end sleep within a few cycles
	AST_RESET_PIN: assert property (
		o_mode == sleep_mode && $fell(i_src.reset_pin_n)
		&& !i_src.on_main_rail |-> ##[1:8] o_mode == battery_mode)
		else $error("reset pin did not wake to battery mode");
	AST_RESTORE: assert property (
		o_mode == sleep_mode && $rose(i_src.supply_restored_event)
		|-> ##[1:8] o_mode != sleep_mode)
		else $error("supply restore did not wake");
endmodule

bind sleep_wakeup_event_control sleep_wakeup_event_control_chk #(.PIN_COUNT(PIN_COUNT)) chk (
	.i_clk(i_clk), .i_rst(i_rst), .i_req(i_req), .i_src(i_src), .o_wake_req(o_wake_req),
	.o_core_restart(o_core_restart), .o_core_off(o_core_off), .o_mode(o_mode),
	.o_pin_force_input(o_pin_force_input), .o_pin_pullup_en(o_pin_pullup_en)
);

// ==== testbench/sleep_wakeup_event_control_tb.sv ====
module sleep_wakeup_event_control_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import wake_ctrl_pkg::*;
	logic           i_clk = 1'b0;
	logic           i_rst = 1'b1;
	reg_req_type    i_req = '0;
	wake_src_type   i_src;
	logic [7:0]     o_rdata;
	logic           o_wake_req, o_core_restart, o_core_off, o_lcd_on;
	power_mode_type o_mode;
	logic [23:0]    o_pin_force_input, o_pin_pullup_en;
	logic           go    = 1'b0;
	logic [3:0]     cmd   = 4'h0;
	int             err_total = 0;
	int             compares  = 0;
	logic [7:0]     d, v, lcdv, sv[4];
	logic           hit;
	logic [71:0]    row;
	// Per source: cmd, two config writes, flag addr, mask, value, cause bit
	localparam logic [71:0] TBL [10] = '{72'h09_f3_01_80_00_80_00_00_01,
		72'h08_ec_08_80_00_f8_08_08_02, 72'h07_80_00_80_00_f8_80_80_04,
		72'h05_a2_e0_80_00_a1_40_40_08, 72'h04_ff_01_88_01_88_02_00_10,
		72'h03_ff_0c_88_04_88_08_00_20, 72'h02_f4_03_80_00_f4_80_80_40,
		72'h06_80_00_80_00_a1_04_04_08, 72'h04_ff_01_80_00_80_00_00_10,
		72'h01_80_00_80_00_80_00_00_80};
	localparam logic [7:0] CLR [8] = '{8'hf8, 8'ha1, 8'hf4, 8'hf3, 8'hec, 8'hff, 8'h88, 8'ha2};
	sleep_wakeup_event_control #(.PIN_COUNT(8)) uut (.i_clk(i_clk), .i_rst(i_rst),
		.i_req(i_req), .o_rdata(o_rdata), .i_src(i_src), .o_wake_req(o_wake_req),
		.o_core_restart(o_core_restart), .o_core_off(o_core_off), .o_mode(o_mode),
		.o_pin_force_input(o_pin_force_input), .o_pin_pullup_en(o_pin_pullup_en),
		.o_lcd_on(o_lcd_on));
	wake_src_model src (.i_clk(i_clk), .i_go(go), .i_cmd(cmd), .o_src(i_src));
	// Clock at 50 MHz
	always #10 i_clk = !i_clk;
	task automatic give_verdict();
		$display("compares %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// Expected mode byte: main rail gives normal mode, otherwise battery mode
	function automatic logic [7:0] exp_mode(logic on_rail);
		return {6'h0, on_rail ? normal_mode : battery_mode};
	endfunction
	task automatic chk8(string name, logic [7:0] exp, logic [7:0] got);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic wr(logic [7:0] a, logic [7:0] val);
		@(posedge i_clk);
		i_req <= '{addr: a, wdata: val, wr: 1'b1, rd: 1'b0};
		@(posedge i_clk);
		i_req.wr <= 1'b0;
	endtask
	task automatic rd(logic [7:0] a);
		@(posedge i_clk);
		i_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge i_clk);
		i_req.rd <= 1'b0;
		#1 d = o_rdata;
	endtask
	task automatic fire(logic [3:0] c);
		@(posedge i_clk);
		go <= 1'b1;
		cmd <= c;
		@(posedge i_clk);
		go <= 1'b0;
	endtask
	task automatic wait_restart(int lim);
		hit = 1'b0;
		for (int i = 0; i < lim && hit !== 1'b1; i++) begin
			@(posedge i_clk);
			#1 hit = o_core_restart;
		end
	endtask
	task automatic settle();
		repeat (2) @(posedge i_clk);
		#1;
	endtask
	// Main sequence
	initial begin
		void'($urandom(32'haaa23802));
		repeat (4) @(posedge i_clk);
		i_rst <= 1'b0;
		for (int i = 0; i < 3; i++) begin
			rd(ADDR_PORT0_PULLUP + 8'(i));
			chk8("pullup_reset", RESET_PULLUP_EN, d);
			v = 8'($urandom);
			wr(ADDR_PORT0_PULLUP + 8'(i), v);
			rd(ADDR_PORT0_PULLUP + 8'(i));
			chk8("pullup_reg", v, d);
			chk8("pullup_out", v, o_pin_pullup_en[8*i +: 8]);
		end
		rd(8'h80);
		chk8("unmapped", UNMAPPED_READ, d);
		wr(ADDR_POWER_CONTROL, 8'hef);
		settle();
		chk8("no_sleep", 8'h00, {7'h0, o_core_off});
		for (int k = 0; k < 2; k++) begin
			fire(4'h0);
			repeat (8) @(posedge i_clk);
			rd(ADDR_PERIPHERAL_CONFIG_CONFIG);
			chk8("source", k ? 8'h00 : 8'h40, d & 8'h40);
			chk8("rail_mode", exp_mode(k == 0), {6'h0, o_mode});
		end
		lcdv = 8'($urandom);
		wr(ADDR_LCD_CONTROL, 8'h01);
		wr(ADDR_LCD_POINTER, 8'h05);
		wr(ADDR_LCD_DATA, lcdv);
		settle();
		chk8("lcd_on", 8'h01, {7'h0, o_lcd_on});
		for (int i = 0; i < 4; i++) begin
			sv[i] = 8'($urandom);
			wr(ADDR_SCRATCH_BASE + 8'(i), sv[i]);
		end
		foreach (TBL[r]) begin
			row = TBL[r];
			foreach (CLR[j]) wr(CLR[j], 8'h00);
			wr(row[63:56], row[55:48]);
			wr(row[47:40], row[39:32]);
			wr(ADDR_POWER_CONTROL, 8'h10);
			settle();
			chk8("core_off", 8'h01, {7'h0, o_core_off});
			chk8("force_input", 8'h01, {7'h0, &o_pin_force_input});
			if (r == 0) begin
				wr(ADDR_LCD_CONTROL, 8'h00);
				settle();
				chk8("lcd_off", 8'h00, {7'h0, o_lcd_on});
			end
			if (r < 2) begin
				wr(row[63:56], 8'h00);
				fire(row[67:64]);
				wait_restart(30);
				chk8("masked", 8'h00, {7'h0, hit});
				wr(row[31:24], 8'h00);
				wr(row[63:56], row[55:48]);
			end
			fire(row[67:64]);
			wait_restart(40);
			chk8("woke", 8'h01, {7'h0, hit});
			if (hit !== 1'b1) give_verdict();
			chk8("mode", exp_mode(1'b0), {6'h0, o_mode});
			rd(ADDR_WAKE_STATUS);
			chk8("cause", row[7:0], d & row[7:0]);
			rd(row[31:24]);
			chk8("flag", row[15:8], d & row[23:16]);
			rd(ADDR_SCRATCH_BASE + 8'(r % 4));
			chk8("scratch", sv[r%4], d);
		end
		wr(ADDR_LCD_POINTER, 8'h05);
		rd(ADDR_LCD_DATA);
		chk8("lcd_mem", lcdv, d);
		settle();
		wr(ADDR_POWER_CONTROL, 8'h10);
		fire(4'h0);
		wait_restart(40);
		chk8("rail_wake", 8'h01, {7'h0, hit});
		chk8("rail_wake_mode", exp_mode(1'b1), {6'h0, o_mode});
		give_verdict();
	end
endmodule
